// file: hw/tsm_monitor_regs.sv
// Control, threshold and status registers of the temperature/supply monitor
`timescale 1ns/10ps
`include "tsm_regs.svh"

module tsm_monitor_regs import tsm_pkg::*; #(
  parameter int unsigned P_STEP_CYCLES = `TSM_STEP_CYCLES_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [`TSM_ADDR_W-1:0] i_addr,
  input wire logic [`TSM_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`TSM_DATA_W-1:0] o_rd_data,
  output logic o_irq,
  output logic o_meas_req,
  input wire logic i_meas_done,
  input wire logic [`TSM_CODE_W-1:0] i_meas_temp,
  input wire logic [`TSM_CODE_W-1:0] i_meas_volt
);

  localparam tsm_state_t ST_RST = '{
    period: `TSM_PERIOD_RST,
    run_ctrl: `TSM_RUN_RST,
    thr: `TSM_THR_RST,
    temp_code: `TSM_TEMP_RST,
    sts: `TSM_EV_RST,
    mask: `TSM_EV_RST,
    state: TSM_IDLE,
    meas_req: 1'b0,
    irq: 1'b0,
    rd_data: '0,
    done_s1: 1'b0,
    done_s2: 1'b0,
    done_s3: 1'b0,
    temp_s1: '0,
    temp_s2: '0,
    volt_s1: '0,
    volt_s2: '0
  };

  // ========================================================================
  // Band comparisons
  // Higher voltage code is a lower supply; higher temperature code is hotter
  function automatic logic at_or_above(input logic [`TSM_CODE_W-1:0] meas, input logic [`TSM_CODE_W-1:0] thr);
    at_or_above = (meas >= thr);
  endfunction

  tsm_state_t st_reg;
  tsm_state_t st_next;
  logic done_edge;
  logic start_wr;
  logic launch;
  logic tmr_start;
  logic tmr_abort;
  logic tmr_expired;
  logic [`TSM_EV_W-1:0] ev;
  logic [`TSM_CODE_W-1:0] thr_uv;
  logic [`TSM_CODE_W-1:0] thr_ov;
  logic [`TSM_CODE_W-1:0] thr_ot;

  assign done_edge = st_reg.done_s2 & ~st_reg.done_s3;
  assign thr_uv = st_reg.thr[`TSM_UV_HI:`TSM_UV_LO];
  assign thr_ov = st_reg.thr[`TSM_OV_HI:`TSM_OV_LO];
  assign thr_ot = st_reg.thr[`TSM_OT_HI:`TSM_OT_LO];
  assign start_wr = i_wr && (i_addr == `TSM_ADDR_RUN) && i_wdata[`TSM_RUN_START];

  // ========================================================================
  // Interval timer
  tsm_period_timer #(
    .P_STEP_CYCLES(P_STEP_CYCLES[`TSM_STEP_CNT_W-1:0])
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_start(tmr_start),
    .i_abort(tmr_abort),
    .i_code(st_reg.period),
    .o_expired(tmr_expired)
  );

  // ========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    ev = '0;
    launch = start_wr | st_reg.run_ctrl[`TSM_RUN_START];

    // Analog handshake crosses in through two flops before use
    st_next.done_s1 = i_meas_done;
    st_next.done_s2 = st_reg.done_s1;
    st_next.done_s3 = st_reg.done_s2;
    st_next.temp_s1 = i_meas_temp;
    st_next.temp_s2 = st_reg.temp_s1;
    st_next.volt_s1 = i_meas_volt;
    st_next.volt_s2 = st_reg.volt_s1;

    // Register writes; reserved bits of control and threshold are kept as written
    if (i_wr) begin
      case (i_addr)
        `TSM_ADDR_PERIOD: st_next.period = i_wdata[`TSM_PERIOD_HI:`TSM_PERIOD_LO];
        `TSM_ADDR_RUN: begin
          st_next.run_ctrl = i_wdata;
          st_next.run_ctrl[`TSM_RUN_START] = st_reg.run_ctrl[`TSM_RUN_START];
        end
        `TSM_ADDR_THR: st_next.thr = i_wdata;
        `TSM_ADDR_IRQ_MASK: st_next.mask = i_wdata[`TSM_EV_W-1:0];
        default: begin
        end
      endcase
    end

    // Run sequencer
    case (st_reg.state)
      TSM_IDLE: begin
        if (launch) begin
          st_next.state = TSM_MEASURE;
          st_next.run_ctrl[`TSM_RUN_START] = 1'b0;
        end
      end
      TSM_WAIT: begin
        if (launch) begin
          st_next.state = TSM_MEASURE;
          st_next.run_ctrl[`TSM_RUN_START] = 1'b0;
          tmr_abort = 1'b1;
        end else if (!st_next.run_ctrl[`TSM_RUN_PERIODIC]) begin
          st_next.state = TSM_IDLE;
          tmr_abort = 1'b1;
        end else if (tmr_expired) begin
          st_next.state = TSM_MEASURE;
        end
      end
      TSM_MEASURE: begin
        // A start during a run is held and launches the next run
        if (start_wr) begin
          st_next.run_ctrl[`TSM_RUN_START] = 1'b1;
        end
        if (done_edge) begin
          st_next.temp_code = st_reg.temp_s2;
          ev[`TSM_EV_DONE] = 1'b1;
          // Bands are ratios of nominal, so no rail select is needed here
          ev[`TSM_EV_UV] = at_or_above(st_reg.volt_s2, thr_uv);
          ev[`TSM_EV_OV] = (thr_ov != `TSM_OV_UNDEF) && at_or_above(thr_ov, st_reg.volt_s2);
          ev[`TSM_EV_OT] = at_or_above(st_reg.temp_s2, thr_ot);
          if (st_next.run_ctrl[`TSM_RUN_PERIODIC]) begin
            st_next.state = TSM_WAIT;
            tmr_start = 1'b1;
          end else begin
            st_next.state = TSM_IDLE;
          end
        end
      end
      default: st_next.state = TSM_IDLE;
    endcase

    st_next.meas_req = (st_next.state == TSM_MEASURE);

    // Read-to-clear status; a new event in the same cycle survives
    if (i_rd && (i_addr == `TSM_ADDR_IRQ_STS)) begin
      st_next.sts = ev;
    end else begin
      st_next.sts = st_reg.sts | ev;
    end
    st_next.irq = |(st_next.sts & st_next.mask);

    // Read data stands only in the cycle after the strobe
    st_next.rd_data = '0;
    if (i_rd) begin
      case (i_addr)
        `TSM_ADDR_PERIOD: st_next.rd_data[`TSM_PERIOD_HI:`TSM_PERIOD_LO] = st_reg.period;
        `TSM_ADDR_RUN: st_next.rd_data = st_reg.run_ctrl;
        `TSM_ADDR_THR: st_next.rd_data = st_reg.thr;
        `TSM_ADDR_TEMP: st_next.rd_data[`TSM_CODE_W-1:0] = st_reg.temp_code;
        `TSM_ADDR_IRQ_STS: st_next.rd_data[`TSM_EV_W-1:0] = st_reg.sts;
        `TSM_ADDR_IRQ_MASK: st_next.rd_data[`TSM_EV_W-1:0] = st_reg.mask;
        default: st_next.rd_data = '0;
      endcase
    end
  end

  // ========================================================================
  // State register; clock enable low freezes everything, bus strobes included
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= ST_RST;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_rd_data = st_reg.rd_data;
  assign o_irq = st_reg.irq;
  assign o_meas_req = st_reg.meas_req;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst || !i_ce);

  AST_START_LAUNCH: assert property (
    start_wr && st_reg.state != TSM_MEASURE |=> st_reg.state == TSM_MEASURE && !st_reg.run_ctrl[`TSM_RUN_START]
  ) else $error("Start write did not launch a run and self-clear");

  AST_START_HELD: assert property (
    start_wr && st_reg.state == TSM_MEASURE && !done_edge |=> st_reg.run_ctrl[`TSM_RUN_START]
  ) else $error("Start during a run was lost");

  AST_SINGLE_RUN_IDLE: assert property (
    st_reg.state == TSM_MEASURE && done_edge && !st_next.run_ctrl[`TSM_RUN_PERIODIC]
      |=> st_reg.state == TSM_IDLE ##1 st_reg.state == TSM_IDLE || st_reg.state == TSM_MEASURE
  ) else $error("Single run did not return to idle");

  AST_PERIODIC_WAIT: assert property (
    st_reg.state == TSM_MEASURE && done_edge && st_next.run_ctrl[`TSM_RUN_PERIODIC] |=> st_reg.state == TSM_WAIT
  ) else $error("Periodic run did not enter the wait interval");

  AST_WAIT_RERUN: assert property (
    st_reg.state == TSM_WAIT && tmr_expired && st_next.run_ctrl[`TSM_RUN_PERIODIC]
      |=> st_reg.state == TSM_MEASURE ##0 o_meas_req
  ) else $error("Interval expiry did not start a new run");

  AST_TEMP_UPDATE: assert property (
    st_reg.state == TSM_MEASURE && done_edge |=> st_reg.temp_code == $past(st_reg.temp_s2)
  ) else $error("Temperature status not captured at run end");

  AST_TEMP_HOLD: assert property (
    !(st_reg.state == TSM_MEASURE && done_edge) |=> $stable(st_reg.temp_code)
  ) else $error("Temperature status changed outside a run end");

  AST_OT_FLAG: assert property (
    st_reg.state == TSM_MEASURE && done_edge && st_reg.temp_s2 >= thr_ot |=> st_reg.sts[`TSM_EV_OT]
  ) else $error("Overtemperature not flagged");

  AST_OV_UNDEF: assert property (
    thr_ov == `TSM_OV_UNDEF && !st_reg.sts[`TSM_EV_OV] && !(i_wr && i_addr == `TSM_ADDR_THR)
      |=> !st_reg.sts[`TSM_EV_OV]
  ) else $error("Overvoltage flagged with undefined threshold");

  AST_RD_ONE_CYCLE: assert property (
    i_rd && i_addr == `TSM_ADDR_TEMP |=> o_rd_data == {{(`TSM_DATA_W-`TSM_CODE_W){1'b0}}, $past(st_reg.temp_code)}
      ##1 (o_rd_data == '0 || $past(i_rd))
  ) else $error("Temperature read data wrong or not one cycle");

  AST_IRQ_LEVEL: assert property (o_irq == |(st_reg.sts & st_reg.mask))
    else $error("Interrupt output disagrees with masked status");

  AST_UV_FLAG: assert property (
    st_reg.state == TSM_MEASURE && done_edge && st_reg.volt_s2 >= thr_uv |=> st_reg.sts[`TSM_EV_UV]
  ) else $error("Undervoltage not flagged");

  AST_OV_FLAG: assert property (
    st_reg.state == TSM_MEASURE && done_edge && thr_ov != `TSM_OV_UNDEF && st_reg.volt_s2 <= thr_ov
      |=> st_reg.sts[`TSM_EV_OV]
  ) else $error("Overvoltage not flagged");

  AST_RUN_DONE: assert property (
    st_reg.state == TSM_MEASURE && done_edge |=> st_reg.sts[`TSM_EV_DONE] && st_reg.state != TSM_MEASURE
  ) else $error("Run end not flagged");

  AST_STS_CLEAR: assert property (
    i_rd && i_addr == `TSM_ADDR_IRQ_STS && !(st_reg.state == TSM_MEASURE && done_edge) |=> st_reg.sts == '0
  ) else $error("Status read did not clear");

  AST_RD_IDLE: assert property (!i_rd |=> o_rd_data == '0)
    else $error("Read data outside the read cycle");

  AST_THR_WRITE: assert property (
    i_wr && i_addr == `TSM_ADDR_THR |=> st_reg.thr == $past(i_wdata)
  ) else $error("Threshold write lost");

  AST_PERIOD_WRITE: assert property (
    i_wr && i_addr == `TSM_ADDR_PERIOD |=> st_reg.period == $past(i_wdata[`TSM_PERIOD_HI:`TSM_PERIOD_LO])
  ) else $error("Cycle period write lost");

  AST_PERIOD_READ: assert property (
    i_rd && i_addr == `TSM_ADDR_PERIOD |=> o_rd_data[`TSM_DATA_W-1:`TSM_PERIOD_W] == '0
  ) else $error("Cycle period read shows upper bits");

  AST_MASK_WRITE: assert property (
    i_wr && i_addr == `TSM_ADDR_IRQ_MASK |=> st_reg.mask == $past(i_wdata[`TSM_EV_W-1:0])
  ) else $error("Interrupt mask write lost");

  AST_START_ZERO: assert property (
    i_wr && i_addr == `TSM_ADDR_RUN && !i_wdata[`TSM_RUN_START] && st_reg.state == TSM_IDLE
      && !st_reg.run_ctrl[`TSM_RUN_START] |=> st_reg.state == TSM_IDLE
  ) else $error("Writing zero to start launched a run");

  AST_WAIT_STOP: assert property (
    st_reg.state == TSM_WAIT && !launch && !st_next.run_ctrl[`TSM_RUN_PERIODIC] |=> st_reg.state == TSM_IDLE
  ) else $error("Clearing periodic mode did not stop the wait");

  COV_SINGLE_RUN: cover property (start_wr ##1 st_reg.state == TSM_MEASURE [*2] ##[1:300] st_reg.state == TSM_IDLE);
  COV_PERIODIC_RERUN: cover property (st_reg.state == TSM_WAIT ##[1:1000] st_reg.state == TSM_MEASURE);
  COV_IRQ_CLEAR: cover property (o_irq ##1 i_rd && i_addr == `TSM_ADDR_IRQ_STS ##1 !o_irq);
  COV_WAIT_LAUNCH: cover property (st_reg.state == TSM_WAIT && launch ##1 st_reg.state == TSM_MEASURE);

endmodule

// file: hw/tsm_regs.svh
// Register map, field positions, reset values and timing for the temperature/supply monitor
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH

// ==========================================================================
// Register addresses
`define TSM_ADDR_W 16
`define TSM_DATA_W 16
`define TSM_ADDR_PERIOD 16'h0480
`define TSM_ADDR_RUN 16'h0481
`define TSM_ADDR_THR 16'h0482
`define TSM_ADDR_TEMP 16'h0483
`define TSM_ADDR_IRQ_STS 16'h04F0
`define TSM_ADDR_IRQ_MASK 16'h04F1

// ==========================================================================
// Reset values
`define TSM_PERIOD_RST 4'h2
`define TSM_RUN_RST 16'h00A2
`define TSM_THR_RST 16'h7007
`define TSM_TEMP_RST 3'h0
`define TSM_EV_RST 4'h0

// ==========================================================================
// Field positions
`define TSM_PERIOD_HI 3
`define TSM_PERIOD_LO 0
`define TSM_RUN_START 0
`define TSM_RUN_PERIODIC 1
`define TSM_UV_HI 14
`define TSM_UV_LO 12
`define TSM_OV_HI 10
`define TSM_OV_LO 8
`define TSM_OT_HI 2
`define TSM_OT_LO 0
`define TSM_CODE_W 3
`define TSM_OV_UNDEF 3'h7
`define TSM_PERIOD_W 4
`define TSM_PERIOD_INVALID 4'h0
`define TSM_PERIOD_MIN 4'h1

// ==========================================================================
// Sticky event bits
`define TSM_EV_W 4
`define TSM_EV_DONE 0
`define TSM_EV_UV 1
`define TSM_EV_OV 2
`define TSM_EV_OT 3

// ==========================================================================
// Timing
`define TSM_STEP_MS 16
`define TSM_CLK_KHZ 40000
`define TSM_STEP_CYCLES_DEF (`TSM_STEP_MS * `TSM_CLK_KHZ)
`define TSM_STEP_CNT_W 20

`endif

// file: hw/tsm_pkg.sv
// Types shared by the temperature/supply monitor modules
`include "tsm_regs.svh"

package tsm_pkg;

  // ========================================================================
  // Run sequencer states
  typedef enum logic [1:0] {
    TSM_IDLE,
    TSM_MEASURE,
    TSM_WAIT
  } tsm_run_state_t;

  // ========================================================================
  // Interval timer state
  typedef struct packed {
    logic [`TSM_STEP_CNT_W-1:0] cyc;
    logic [`TSM_PERIOD_W-1:0] steps_left;
    logic running;
    logic expired;
  } tsm_tmr_state_t;

  // ========================================================================
  // Top-level state
  typedef struct packed {
    logic [`TSM_PERIOD_W-1:0] period;
    logic [`TSM_DATA_W-1:0] run_ctrl;
    logic [`TSM_DATA_W-1:0] thr;
    logic [`TSM_CODE_W-1:0] temp_code;
    logic [`TSM_EV_W-1:0] sts;
    logic [`TSM_EV_W-1:0] mask;
    tsm_run_state_t state;
    logic meas_req;
    logic irq;
    logic [`TSM_DATA_W-1:0] rd_data;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    logic [`TSM_CODE_W-1:0] temp_s1;
    logic [`TSM_CODE_W-1:0] temp_s2;
    logic [`TSM_CODE_W-1:0] volt_s1;
    logic [`TSM_CODE_W-1:0] volt_s2;
  } tsm_state_t;

endpackage

// file: hw/tsm_period_timer.sv
// Interval timer between periodic monitor runs
`timescale 1ns/10ps
`include "tsm_regs.svh"

module tsm_period_timer import tsm_pkg::*; #(
  parameter logic [`TSM_STEP_CNT_W-1:0] P_STEP_CYCLES = `TSM_STEP_CNT_W'(`TSM_STEP_CYCLES_DEF)
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [`TSM_PERIOD_W-1:0] i_code,
  output logic o_expired
);

  localparam tsm_tmr_state_t TMR_RST = '{cyc: '0, steps_left: '0, running: 1'b0, expired: 1'b0};

  tsm_tmr_state_t tmr_reg;
  tsm_tmr_state_t tmr_next;

  // ========================================================================
  // Next state
  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.expired = 1'b0;
    if (i_abort) begin
      tmr_next.running = 1'b0;
    end else if (i_start) begin
      tmr_next.running = 1'b1;
      tmr_next.cyc = '0;
      // Code 0 is invalid; run it as the shortest step
      tmr_next.steps_left = (i_code == `TSM_PERIOD_INVALID) ? `TSM_PERIOD_MIN : i_code;
    end else if (tmr_reg.running) begin
      if (tmr_reg.cyc == P_STEP_CYCLES - `TSM_STEP_CNT_W'(1)) begin
        tmr_next.cyc = '0;
        if (tmr_reg.steps_left == `TSM_PERIOD_MIN) begin
          tmr_next.running = 1'b0;
          tmr_next.expired = 1'b1;
        end else begin
          tmr_next.steps_left = tmr_reg.steps_left - `TSM_PERIOD_MIN;
        end
      end else begin
        tmr_next.cyc = tmr_reg.cyc + `TSM_STEP_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tmr_reg <= TMR_RST;
    end else if (i_ce) begin
      tmr_reg <= tmr_next;
    end
  end

  assign o_expired = tmr_reg.expired;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst || !i_ce);

  AST_TMR_ARM: assert property (i_start && !i_abort |=> tmr_reg.running && tmr_reg.steps_left != '0)
    else $error("Timer not armed after start");
  AST_TMR_PULSE: assert property (tmr_reg.expired |=> !tmr_reg.expired && !tmr_reg.running)
    else $error("Timer expiry not a single pulse");

endmodule

// file: tb/tsm_monitor_regs_test.sv
// Self-checking testbench for the temperature/supply monitor register block
`timescale 1ns/10ps
`include "tsm_regs.svh"

module tsm_monitor_regs_test import tsm_pkg::*;;
  // ==========================================================================
  // Signals
  localparam int STEP = 8;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_meas_done = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic [2:0] i_meas_temp = 3'h0;
  logic [2:0] i_meas_volt = 3'h0;
  logic [15:0] o_rd_data;
  logic o_irq;
  logic o_meas_req;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  // Short step keeps periodic runs within a few dozen cycles
  tsm_monitor_regs #(.P_STEP_CYCLES(STEP)) dut (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rd_data(o_rd_data),
    .o_irq(o_irq),
    .o_meas_req(o_meas_req),
    .i_meas_done(i_meas_done),
    .i_meas_temp(i_meas_temp),
    .i_meas_volt(i_meas_volt)
  );

  always #12.5 i_clk_sys = ~i_clk_sys;

  // ==========================================================================
  // Timeout
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic test_done();
    if (fail_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string n);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1;
    chk(n, e, o_rd_data);
  endtask

  task automatic wait_req(input logic lv, input int lim, output int n);
    n = 0;
    while (o_meas_req !== lv && n < lim) begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end
  endtask

  // Analog side: codes held steady while done is high
  task automatic run(input logic [2:0] t, input logic [2:0] v);
    int n;
    @(posedge i_clk_sys);
    i_meas_temp <= t;
    i_meas_volt <= v;
    wait_req(1'b1, 300, n);
    chk("meas_req rise", 16'h0001, {15'h0, o_meas_req});
    repeat (3) @(posedge i_clk_sys);
    i_meas_done <= 1'b1;
    // Two sync flops plus state register: run ends three edges later
    repeat (3) @(posedge i_clk_sys);
    i_meas_done <= 1'b0;
    #1;
    chk("meas_req fall", 16'h0000, {15'h0, o_meas_req});
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk("irq after reset", 16'h0000, {15'h0, o_irq});
    chk("meas_req after reset", 16'h0000, {15'h0, o_meas_req});
    rd(`TSM_ADDR_PERIOD, 16'h0002, "period reset");
    rd(`TSM_ADDR_RUN, 16'h00A2, "run reset");
    rd(`TSM_ADDR_THR, 16'h7007, "thr reset");
    rd(`TSM_ADDR_TEMP, 16'h0000, "temp reset");
    rd(`TSM_ADDR_IRQ_STS, 16'h0000, "sts reset");
    rd(`TSM_ADDR_IRQ_MASK, 16'h0000, "mask reset");
    rd(16'h0000, 16'h0000, "unmapped reset");
  endtask

  task automatic t_regs();
    wr(`TSM_ADDR_THR, 16'hFFFF);
    rd(`TSM_ADDR_THR, 16'hFFFF, "thr rw");
    wr(`TSM_ADDR_TEMP, 16'h0007);
    rd(`TSM_ADDR_TEMP, 16'h0000, "temp ro");
    wr(16'h0100, 16'hFFFF);
    rd(16'h0100, 16'h0000, "unmapped");
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    wr(`TSM_ADDR_THR, 16'h0000);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    rd(`TSM_ADDR_THR, 16'hFFFF, "thr frozen");
    wr(`TSM_ADDR_PERIOD, 16'hFFFF);
    rd(`TSM_ADDR_PERIOD, 16'h000F, "period width");
    wr(`TSM_ADDR_RUN, 16'hFFFC);
    rd(`TSM_ADDR_RUN, 16'hFFFC, "run rw");
    chk("no start", 16'h0000, {15'h0, o_meas_req});
    wr(`TSM_ADDR_RUN, 16'h0000);
  endtask

  task automatic t_single();
    wr(`TSM_ADDR_THR, 16'h3105);
    wr(`TSM_ADDR_RUN, 16'h0001);
    chk("start launches", 16'h0001, {15'h0, o_meas_req});
    rd(`TSM_ADDR_RUN, 16'h0000, "start clears");
    run(3'h5, 3'h3);
    rd(`TSM_ADDR_TEMP, 16'h0005, "temp result");
    rd(`TSM_ADDR_IRQ_STS, 16'h000B, "uv ot flags");
    rd(`TSM_ADDR_IRQ_STS, 16'h0000, "sts cleared");
    chk("irq masked", 16'h0000, {15'h0, o_irq});
    repeat (40) @(posedge i_clk_sys);
    #1;
    chk("single run", 16'h0000, {15'h0, o_meas_req});
  endtask

  task automatic t_irq();
    wr(`TSM_ADDR_IRQ_MASK, 16'h0004);
    wr(`TSM_ADDR_RUN, 16'h0001);
    run(3'h4, 3'h1);
    @(posedge i_clk_sys);
    i_meas_temp <= 3'h7;
    #1;
    chk("irq raised", 16'h0001, {15'h0, o_irq});
    rd(`TSM_ADDR_IRQ_STS, 16'h0005, "ov flag");
    @(posedge i_clk_sys);
    #1;
    chk("irq cleared", 16'h0000, {15'h0, o_irq});
    rd(`TSM_ADDR_TEMP, 16'h0004, "temp held");
    // Undefined overvoltage code must never flag
    wr(`TSM_ADDR_THR, 16'h0700);
    wr(`TSM_ADDR_RUN, 16'h0001);
    run(3'h0, 3'h0);
    rd(`TSM_ADDR_IRQ_STS, 16'h000B, "ov undef");
    rd(`TSM_ADDR_TEMP, 16'h0000, "temp low band");
  endtask

  // Start written during a run is held and relaunches after it
  task automatic t_pending();
    wr(`TSM_ADDR_RUN, 16'h0001);
    wr(`TSM_ADDR_RUN, 16'h0001);
    rd(`TSM_ADDR_RUN, 16'h0001, "start pending");
    run(3'h1, 3'h2);
    @(posedge i_clk_sys);
    #1;
    chk("pending launch", 16'h0001, {15'h0, o_meas_req});
    run(3'h1, 3'h2);
    rd(`TSM_ADDR_IRQ_STS, 16'h0001, "two runs done");
  endtask

  // Start and periodic clear while waiting out the interval
  task automatic t_wait();
    int n;
    wr(`TSM_ADDR_PERIOD, 16'h000F);
    wr(`TSM_ADDR_RUN, 16'h0003);
    run(3'h2, 3'h2);
    wr(`TSM_ADDR_RUN, 16'h0003);
    chk("wait launch", 16'h0001, {15'h0, o_meas_req});
    run(3'h2, 3'h2);
    wr(`TSM_ADDR_RUN, 16'h0000);
    wait_req(1'b1, 200, n);
    chk("wait abort", 16'h0000, {15'h0, o_meas_req});
    rd(`TSM_ADDR_IRQ_STS, 16'h0001, "wait runs done");
  endtask

  task automatic t_period(input logic [3:0] code);
    int n;
    int eff;
    eff = (code == 4'h0) ? 1 : int'(code);
    wr(`TSM_ADDR_PERIOD, {12'h000, code});
    wr(`TSM_ADDR_RUN, 16'h0003);
    run(3'h2, 3'h2);
    wait_req(1'b1, 200, n);
    chk("periodic rerun", 16'h0001, {15'h0, o_meas_req});
    // Code steps counted from run end, then one edge to relaunch
    chk("period gap", 16'(eff * STEP + 1), 16'(n));
    wr(`TSM_ADDR_RUN, 16'h0000);
    run(3'h2, 3'h2);
    wait_req(1'b1, 40, n);
    chk("periodic off", 16'h0000, {15'h0, o_meas_req});
    rd(`TSM_ADDR_IRQ_STS, 16'h0001, "done only");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    t_reset();
    t_regs();
    t_single();
    t_irq();
    wr(`TSM_ADDR_THR, 16'h7007);
    t_pending();
    t_wait();
    t_period(4'h1);
    t_period(4'h3);
    t_period(4'h0);
    test_done();
  end
endmodule
